// [logic/swd_pkg.sv]
// Constants shared by the software watchdog timer.
package swd_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] SWD_REF_OFS = 8'h00;
    localparam logic [7:0] SWD_CNT_OFS = 8'h04;
    localparam logic [7:0] SWD_CTL_OFS = 8'h08;
    localparam logic [7:0] SWD_STS_OFS = 8'h0c;
    localparam logic [7:0] SWD_MSK_OFS = 8'h10;
    localparam logic [7:0] SWD_PIN_OFS = 8'h14;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SWD_REF_EN_BIT = 0;
    localparam int SWD_CTL_FRZ_BIT = 0;
    localparam int SWD_CTL_BUS_WIDTH_SELECT_BIT = 1;
    localparam int SWD_STS_TMO_BIT = 0;
    localparam int SWD_PIN_FUNC_BIT = 0;
    localparam int SWD_PIN_LVL_BIT = 1;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] SWD_REF_RST = 16'hffff;
    localparam logic [1:0] SWD_CTL_RST = 2'h2;
    localparam logic [1:0] SWD_PIN_RST = 2'h3;
    localparam logic [0:0] SWD_STS_RST = 1'h0;
    localparam logic [0:0] SWD_MSK_RST = 1'h0;
    // ----------------------------------------------------------------
    // Timing counts: divider ratios, and lengths in master clock cycles
    // ----------------------------------------------------------------
    localparam int SWD_DIV_MAIN = 16;
    localparam int SWD_PRESCALE = 256;
    localparam int SWD_TICK_CYCLES = SWD_DIV_MAIN * SWD_PRESCALE;
    localparam logic [3:0] SWD_DIV_LAST = 4'(SWD_DIV_MAIN - 1);
    localparam logic [7:0] SWD_PRE_LAST = 8'(SWD_PRESCALE - 1);
    localparam logic [12:0] SWD_GAP_LAST = 13'(SWD_TICK_CYCLES - 1);
    localparam logic [4:0] SWD_PULSE_CYCLES = 5'd16;
    // ----------------------------------------------------------------
    // Bus responses
    // ----------------------------------------------------------------
    localparam logic [1:0] SWD_RESP_OKAY = 2'h0;
    localparam logic [1:0] SWD_RESP_SLVERR = 2'h2;
endpackage : swd_pkg

// [logic/swd_watchdog.sv]
// Software watchdog timer with an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module swd_watchdog (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic freeze_req,
    output logic timeout_pulse_n,
    output logic timeout_pulse_n_irq,
    output logic port_b_line_seven_out,
    output logic port_b_line_seven_oe_n
);
    import swd_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic aw_q, aw_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic w_q, w_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [15:0] ref_q, ref_d;
    logic [1:0] ctl_q, ctl_d;
    logic [0:0] sts_q, sts_d;
    logic [0:0] msk_q, msk_d;
    logic [1:0] pin_q, pin_d;
    logic susp_q, susp_d;
    logic [3:0] div_q, div_d;
    logic [7:0] pre_q, pre_d;
    logic [15:0] cnt_q, cnt_d;
    logic [4:0] pls_q, pls_d;
    logic pls_n_q, pls_n_d;
    logic [12:0] gap_q, gap_d;
    logic do_wr;
    logic wr_cnt;
    logic sts_clr;
    logic run;
    logic tick;
    logic tmo;
    logic [15:0] cnt_inc;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign do_wr = aw_q && w_q && !bvalid_q;

    always_comb begin
        aw_d = aw_q;
        awaddr_d = awaddr_q;
        w_d = w_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        ref_d = ref_q;
        ctl_d = ctl_q;
        msk_d = msk_q;
        pin_d = pin_q;
        susp_d = susp_q;
        wr_cnt = 1'b0;
        sts_clr = 1'b0;
        if (s_axi_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q) begin
            w_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_wr) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = SWD_RESP_OKAY;
            case (awaddr_q)
                SWD_REF_OFS: begin
                    if (wstrb_q[0]) begin
                        ref_d[7:0] = wdata_q[7:0];
                    end
                    if (wstrb_q[1]) begin
                        ref_d[15:8] = wdata_q[15:8];
                    end
                    // In byte-wide mode the compare waits for the low byte.
                    if (!ctl_q[SWD_CTL_BUS_WIDTH_SELECT_BIT]) begin
                        if (wstrb_q[0]) begin
                            susp_d = 1'b0;
                        end else if (wstrb_q[1]) begin
                            susp_d = 1'b1;
                        end
                    end else begin
                        susp_d = 1'b0;
                    end
                end
                SWD_CNT_OFS: wr_cnt = 1'b1;
                SWD_CTL_OFS: begin
                    if (wstrb_q[0]) begin
                        ctl_d = wdata_q[1:0];
                    end
                end
                SWD_STS_OFS: sts_clr = wstrb_q[0] && wdata_q[SWD_STS_TMO_BIT];
                SWD_MSK_OFS: begin
                    if (wstrb_q[0]) begin
                        msk_d = wdata_q[0:0];
                    end
                end
                SWD_PIN_OFS: begin
                    if (wstrb_q[0]) begin
                        pin_d = wdata_q[1:0];
                    end
                end
                default: bresp_d = SWD_RESP_SLVERR;
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = SWD_RESP_OKAY;
            rdata_d = 32'h0;
            case (s_axi_araddr)
                SWD_REF_OFS: rdata_d[15:0] = ref_q;
                SWD_CNT_OFS: rdata_d[15:0] = cnt_q;
                SWD_CTL_OFS: rdata_d[1:0] = ctl_q;
                SWD_STS_OFS: rdata_d[0:0] = sts_q;
                SWD_MSK_OFS: rdata_d[0:0] = msk_q;
                SWD_PIN_OFS: rdata_d[1:0] = pin_q;
                default: rresp_d = SWD_RESP_SLVERR;
            endcase
        end
        // A timeout in the clearing cycle keeps the bit set.
        sts_d = (sts_q & ~sts_clr) | tmo;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            awaddr_q <= 8'h0;
            w_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= SWD_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= SWD_RESP_OKAY;
            ref_q <= SWD_REF_RST;
            ctl_q <= SWD_CTL_RST;
            sts_q <= SWD_STS_RST;
            msk_q <= SWD_MSK_RST;
            pin_q <= SWD_PIN_RST;
            susp_q <= 1'b0;
        end else begin
            aw_q <= aw_d;
            awaddr_q <= awaddr_d;
            w_q <= w_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            ref_q <= ref_d;
            ctl_q <= ctl_d;
            sts_q <= sts_d;
            msk_q <= msk_d;
            pin_q <= pin_d;
            susp_q <= susp_d;
        end
    end

    // ----------------------------------------------------------------
    // Timer
    // ----------------------------------------------------------------
    assign run = ref_q[SWD_REF_EN_BIT] && !(freeze_req && ctl_q[SWD_CTL_FRZ_BIT]);
    assign tick = run && div_q == SWD_DIV_LAST && pre_q == SWD_PRE_LAST;
    assign cnt_inc = cnt_q + 16'h0001;
    assign tmo = tick && !susp_q && cnt_inc[15:1] == ref_q[15:1];

    always_comb begin
        div_d = div_q;
        pre_d = pre_q;
        cnt_d = cnt_q;
        pls_d = pls_q;
        gap_d = gap_q;
        if (run) begin
            div_d = div_q + 4'h1;
            gap_d = gap_q + 13'h1;
            if (div_q == SWD_DIV_LAST) begin
                pre_d = pre_q + 8'h1;
            end
        end
        if (tick) begin
            gap_d = 13'h0;
            cnt_d = tmo ? 16'h0 : cnt_inc;
        end
        if (wr_cnt) begin
            cnt_d = 16'h0;
        end
        if (tmo) begin
            pls_d = SWD_PULSE_CYCLES;
        end else if (pls_q != 5'h0) begin
            pls_d = pls_q - 5'h1;
        end
        pls_n_d = pls_d == 5'h0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 4'h0;
            pre_q <= 8'h0;
            cnt_q <= 16'h0;
            pls_q <= 5'h0;
            pls_n_q <= 1'b1;
            gap_q <= 13'h0;
        end else begin
            div_q <= div_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            pls_q <= pls_d;
            pls_n_q <= pls_n_d;
            gap_q <= gap_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign timeout_pulse_n = pls_n_q;
    assign timeout_pulse_n_irq = |(sts_q & msk_q);
    assign port_b_line_seven_out = 1'b0;
    // Open drain: the enable is low only while the pin is pulled low.
    assign port_b_line_seven_oe_n = pin_q[SWD_PIN_FUNC_BIT] ? pls_n_q
                                  : pin_q[SWD_PIN_LVL_BIT];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    pulse_len_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tmo |=> (!timeout_pulse_n) [*8] ##1 (!timeout_pulse_n) [*8] ##1 timeout_pulse_n)
        else $error("watchdog pulse is not 16 cycles long");

    restart_zero_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tmo |=> cnt_q == 16'h0 && sts_q[SWD_STS_TMO_BIT])
        else $error("timeout did not restart count or flag interrupt");

    tick_spacing_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tick |-> gap_q == SWD_GAP_LAST)
        else $error("counter step not 4096 running clocks");

    freeze_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        freeze_req && ctl_q[SWD_CTL_FRZ_BIT] && !wr_cnt
        |=> $stable(cnt_q) && $stable(pre_q) && $stable(div_q))
        else $error("timer moved while frozen");

    sts_sticky_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sts_q[SWD_STS_TMO_BIT] && !sts_clr |=> sts_q[SWD_STS_TMO_BIT])
        else $error("pending bit lost without a clear");

    count_read_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == SWD_CNT_OFS
        |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(cnt_q))
        else $error("count read returned wrong value");

    count_clear_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_cnt |=> cnt_q == 16'h0)
        else $error("count write did not clear count");

    compare_gate_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tmo |-> tick && ref_q[SWD_REF_EN_BIT] && !susp_q
        && (cnt_q[15:1] == ref_q[15:1] || cnt_q[15:1] + 15'h1 == ref_q[15:1]))
        else $error("timeout while disabled or suspended");

    reset_state_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> ref_q == SWD_REF_RST && !ctl_q[SWD_CTL_FRZ_BIT]
        && pin_q[SWD_PIN_FUNC_BIT] && cnt_q == 16'h0 ##1 div_q == 4'h1 || freeze_req)
        else $error("wrong state after reset");

    count_step_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tick && !tmo && !wr_cnt |=> cnt_q == $past(cnt_q) + 16'h1)
        else $error("count did not advance by one on a step");

    count_still_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !tick && !wr_cnt |=> $stable(cnt_q))
        else $error("count moved between steps");

    disable_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !ref_q[SWD_REF_EN_BIT] |=> $stable(div_q) && $stable(pre_q))
        else $error("prescaler ran while disabled");

    irq_raise_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tmo && msk_q[0] && !do_wr |=> timeout_pulse_n_irq)
        else $error("unmasked timeout raised no interrupt");

    pin_func_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        pin_q[SWD_PIN_FUNC_BIT] && !timeout_pulse_n |-> !port_b_line_seven_oe_n)
        else $error("pin not pulled low during pulse");

    upper_suspend_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        do_wr && awaddr_q == SWD_REF_OFS && !ctl_q[SWD_CTL_BUS_WIDTH_SELECT_BIT]
        && wstrb_q[1:0] == 2'b10 |=> susp_q)
        else $error("upper byte write did not suspend compare");
endmodule : swd_watchdog

// [tb/swd_host_model.sv]
// Host side model: pulled-up open-drain pin and interrupt pending latch.
`timescale 1ns/1ps
module swd_host_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic irq,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output logic pin_level,
    output logic pending_q
);
    logic pending_d;
    // The pin has a pull-up, so it reads high whenever nobody pulls it down.
    assign pin_level = pin_oe_n ? 1'b1 : pin_out;
    always_comb begin
        pending_d = pending_q | irq;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= pending_d;
        end
    end
endmodule : swd_host_model

// [tb/testbench.sv]
// Self-checking testbench of the software watchdog timer.
`timescale 1ns/1ps
module testbench;
    import swd_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic freeze_req = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pulse_n, irq;
    logic pin_out, pin_oe_n, pin_level, pending;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    logic pulse_prev = 1'b1;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_falls = 0;
    int last_fall = 0;
    int prev_fall = 0;
    int low_len = 0;

    swd_watchdog DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .freeze_req(freeze_req),
        .timeout_pulse_n(pulse_n), .timeout_pulse_n_irq(irq), .port_b_line_seven_out(pin_out),
        .port_b_line_seven_oe_n(pin_oe_n));
    swd_host_model host (.aclk(aclk), .aresetn(aresetn), .irq(irq), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_level(pin_level), .pending_q(pending));

    always #2.5 aclk = ~aclk;

    // Measures the pulse: fall times and the length of each low stretch.
    always @(posedge aclk) begin
        if (aresetn) begin
            cyc <= cyc + 1;
        end
        if (pulse_prev && !pulse_n) begin
            n_falls <= n_falls + 1;
            prev_fall <= last_fall;
            last_fall <= cyc;
            low_len <= 1;
        end else if (!pulse_n) begin
            low_len <= low_len + 1;
        end
        pulse_prev <= pulse_n;
        if (cyc >= 90000) begin
            err_total = err_total + 1;
            wrap_up;
        end
    end

    task automatic wrap_up;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_v

    task automatic chk_b(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s: got %b expected %b", $time, what, got, exp);
        end
    endtask : chk_b

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_cyc

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] ofs [5] = '{SWD_REF_OFS, SWD_CTL_OFS, SWD_STS_OFS, SWD_MSK_OFS, SWD_PIN_OFS};
        logic [31:0] exp [5] = '{32'(SWD_REF_RST), 32'(SWD_CTL_RST), 32'(SWD_STS_RST),
            32'(SWD_MSK_RST), 32'(SWD_PIN_RST)};
        chk_b(pulse_n, 1'b1, "pulse idle after reset");
        for (int i = 0; i < 5; i++) begin
            axi_rd(ofs[i]);
            chk_v(rd, exp[i], "reset value");
        end
        axi_rd(8'h18);
        chk_v(32'(rsp), 32'(SWD_RESP_SLVERR), "unmapped read response");
        chk_v(rd, 32'h0, "unmapped read data");
        axi_wr(8'h18, 32'hffff_ffff, 4'hf);
        chk_v(32'(rsp), 32'(SWD_RESP_SLVERR), "unmapped write response");
        chk_b(pin_level, 1'b1, "pin released while idle");
        axi_wr(SWD_PIN_OFS, 32'h0, 4'h1);
        chk_b(pin_level, 1'b0, "pin driven low as port line");
        axi_wr(SWD_PIN_OFS, 32'h2, 4'h1);
        chk_b(pin_level, 1'b1, "pin released as port line");
        axi_wr(SWD_PIN_OFS, 32'(SWD_PIN_RST), 4'h1);
    endtask : t_reset

    task automatic t_count;
        while (cyc < 4000) @(posedge aclk);
        axi_rd(SWD_CNT_OFS);
        chk_v(rd, 32'h0, "count before first tick");
        while (cyc < 5000) @(posedge aclk);
        axi_rd(SWD_CNT_OFS);
        chk_v(rd, 32'h1, "count after first tick");
        axi_wr(SWD_CNT_OFS, 32'h0000_1234, 4'hf);
        chk_v(32'(rsp), 32'(SWD_RESP_OKAY), "count write response");
        axi_rd(SWD_CNT_OFS);
        chk_v(rd, 32'h0, "count cleared, data ignored");
    endtask : t_count

    task automatic t_timeout;
        int n0;
        axi_wr(SWD_REF_OFS, 32'h3, 4'h3);
        axi_wr(SWD_MSK_OFS, 32'h1, 4'h1);
        axi_wr(SWD_CNT_OFS, 32'h0, 4'hf);
        n0 = n_falls;
        while (n_falls == n0) @(posedge aclk);
        wait_cyc(2);
        chk_b(pin_level, 1'b0, "pin low during pulse");
        chk_b(irq, 1'b1, "interrupt raised");
        chk_b(pending, 1'b1, "request seen by host");
        wait_cyc(18);
        chk_v(32'(low_len), 32'h10, "pulse width");
        axi_rd(SWD_CNT_OFS);
        chk_v(rd, 32'h0, "count restarted");
        axi_wr(SWD_STS_OFS, 32'h1, 4'h1);
        axi_rd(SWD_STS_OFS);
        chk_v(rd, 32'h0, "status cleared by one");
        chk_b(irq, 1'b0, "interrupt dropped");
        n0 = n_falls;
        while (n_falls == n0) @(posedge aclk);
        wait_cyc(2);
        chk_v(32'(last_fall - prev_fall), 32'h2000, "timeout period");
        axi_wr(SWD_MSK_OFS, 32'h0, 4'h1);
        chk_b(irq, 1'b0, "masked interrupt");
        axi_rd(SWD_STS_OFS);
        chk_v(rd, 32'h1, "status set on each match");
    endtask : t_timeout

    task automatic t_freeze;
        logic [31:0] c0;
        axi_wr(SWD_CTL_OFS, 32'h3, 4'h1);
        freeze_req <= 1'b1;
        axi_rd(SWD_CNT_OFS);
        c0 = rd;
        wait_cyc(4200);
        axi_rd(SWD_CNT_OFS);
        chk_v(rd, c0, "count held in freeze");
        axi_rd(SWD_STS_OFS);
        chk_v(rd, 32'h1, "status kept in freeze");
        axi_wr(SWD_CTL_OFS, 32'h2, 4'h1);
        axi_rd(SWD_CNT_OFS);
        c0 = rd;
        wait_cyc(4200);
        axi_rd(SWD_CNT_OFS);
        chk_b(rd !== c0, 1'b1, "count runs with freeze disabled");
        freeze_req <= 1'b0;
    endtask : t_freeze

    task automatic t_service;
        int n0;
        axi_wr(SWD_CNT_OFS, 32'h0, 4'hf);
        n0 = n_falls;
        // Servicing every 3000 cycles keeps the count below the reference.
        repeat (3) begin
            axi_wr(SWD_CNT_OFS, 32'h0, 4'hf);
            wait_cyc(3000);
        end
        chk_v(32'(n_falls - n0), 32'h0, "no timeout while serviced");
    endtask : t_service

    task automatic t_narrow;
        int n0;
        axi_wr(SWD_CTL_OFS, 32'h0, 4'h1);
        axi_wr(SWD_REF_OFS, 32'h0, 4'h2);
        axi_wr(SWD_CNT_OFS, 32'h0, 4'hf);
        n0 = n_falls;
        wait_cyc(9000);
        chk_v(32'(n_falls - n0), 32'h0, "compare suspended");
        axi_wr(SWD_REF_OFS, 32'h3, 4'h1);
        axi_wr(SWD_CNT_OFS, 32'h0, 4'hf);
        n0 = n_falls;
        wait_cyc(8300);
        chk_v(32'(n_falls - n0), 32'h1, "compare resumed");
        axi_wr(SWD_CTL_OFS, 32'h2, 4'h1);
    endtask : t_narrow

    task automatic t_disable;
        logic [31:0] c0;
        int n0;
        axi_wr(SWD_REF_OFS, 32'h2, 4'h3);
        axi_rd(SWD_CNT_OFS);
        c0 = rd;
        n0 = n_falls;
        wait_cyc(8300);
        axi_rd(SWD_CNT_OFS);
        chk_v(rd, c0, "count held when disabled");
        chk_v(32'(n_falls - n0), 32'h0, "no timeout when disabled");
    endtask : t_disable

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_count;
        t_timeout;
        t_freeze;
        t_service;
        t_narrow;
        t_disable;
        wrap_up;
    end
endmodule : testbench
